/* inc/ldpt_pkg.sv */
// Package with addresses, field positions, reset values and timing constants of the timer.
package ldpt_pkg;

	// Byte addresses of the I/O registers.
	localparam logic [15:0] ADDR_COUNT_BYTE0  = 16'h0218; // Lowest counter byte, captures the count.
	localparam logic [15:0] ADDR_COUNT_BYTE1  = 16'h0219; // Bits 15 to 8.
	localparam logic [15:0] ADDR_COUNT_BYTE2  = 16'h021a; // Bits 23 to 16.
	localparam logic [15:0] ADDR_COUNT_BYTE3  = 16'h021b; // Bits 31 to 24.
	localparam logic [15:0] ADDR_STATUS_CTRL  = 16'h021c; // Status and control byte.

	// Field positions inside the status and control byte.
	localparam int unsigned CTRL_IRQ_EN_BIT   = 7;        // Interrupt enable.
	localparam int unsigned CTRL_CLK_SEL_BIT  = 5;        // Count clock select.
	localparam int unsigned CTRL_FLAG_BIT     = 4;        // Wrap event flag.
	localparam int unsigned CTRL_MODE_LSB     = 1;        // Low bit of the mode field.
	localparam int unsigned CTRL_RUN_BIT      = 0;        // Run bit.
	localparam int unsigned MODE_W            = 3;        // Width of the mode field.
	localparam int unsigned BYTE_W            = 8;        // Width of one register byte.
	localparam int unsigned COUNT_BYTES       = 4;        // Bytes in the counter.

	// Reset values.
	localparam logic        RST_IRQ_EN        = 1'h0;     // Interrupt disabled.
	localparam logic        RST_CLK_SEL       = 1'h0;     // 1 MHz count clock.
	localparam logic        RST_FLAG          = 1'h0;     // No event pending.
	localparam logic [2:0]  RST_MODE          = 3'h0;     // Timestamp mode.
	localparam logic        RST_RUN           = 1'h0;     // Counter stopped.
	localparam logic [31:0] RST_COUNT         = 32'h0;    // Power-on count.
	localparam logic [31:0] READ_IDLE         = 32'h0;    // Data of an unmapped read.
	localparam logic [7:0]  RESERVED_ZERO     = 8'h0;     // Reserved bits read as zero.

	// Mode codes and terminal counts of each interval.
	localparam logic [2:0]  MODE_TIMESTAMP    = 3'h0;     // Free run with wrap at all ones.
	localparam logic [31:0] COUNT_ALL_ONES    = 32'hffffffff; // Timestamp terminal count.
	localparam logic [31:0] TERM_RATE_1       = 32'h0000270f; // 100 Hz at 1 MHz.
	localparam logic [31:0] TERM_RATE_2       = 32'h00001387; // 200 Hz at 1 MHz.
	localparam logic [31:0] TERM_RATE_3       = 32'h000007cf; // 500 Hz at 1 MHz.
	localparam logic [31:0] TERM_RATE_4       = 32'h000003e7; // 1000 Hz at 1 MHz.
	localparam logic [31:0] TERM_RATE_5       = 32'h000001f3; // 2000 Hz at 1 MHz.
	localparam logic [31:0] TERM_RATE_6       = 32'h000000c7; // 5000 Hz at 1 MHz.
	localparam logic [31:0] TERM_RATE_7       = 32'h00000063; // 10000 Hz at 1 MHz.

	// Clock rates in hertz; the tick generator is a phase accumulator over the system rate.
	localparam int unsigned SYS_CLK_HZ        = 40_000_000; // System clock.
	localparam int unsigned FAST_COUNT_HZ     = 1_000_000;  // Default count clock.
	localparam int unsigned SLOW_COUNT_HZ     = 32_768;     // Alternative count clock.
	localparam int unsigned PHASE_W           = 27;         // Holds system rate plus one step.
	localparam logic [PHASE_W-1:0] PHASE_MOD  = PHASE_W'(SYS_CLK_HZ);    // Wrap point.
	localparam logic [PHASE_W-1:0] STEP_FAST  = PHASE_W'(FAST_COUNT_HZ); // Step for 1 MHz.
	localparam logic [PHASE_W-1:0] STEP_SLOW  = PHASE_W'(SLOW_COUNT_HZ); // Step for 32.768 kHz.
	localparam logic [PHASE_W-1:0] PHASE_ZERO = '0;                      // Reset phase.

endpackage : ldpt_pkg

/* inc/ldpt_link_if.sv */
// Interface joining the timer core to its tick generator and terminal count table.
`timescale 1ns/1ps
interface ldpt_link_if;
	logic        count_tick; // One-cycle pulse per count clock period.
	logic        slow_sel;   // High selects the 32.768 kHz count clock.
	logic [2:0]  mode;       // Mode field of the control byte.
	logic [31:0] term_value; // Last count value of the current interval.

	modport tickgen (input slow_sel, output count_tick);
	modport lut     (input mode, output term_value);
	modport core    (output slow_sel, output mode, input count_tick, input term_value);
endinterface : ldpt_link_if

/* logic/ldpt_tick_gen.sv */
// Count clock tick generator, a phase accumulator on the system clock.
`timescale 1ns/1ps
module ldpt_tick_gen (
	input wire logic    clk_sys, // System clock, 40 MHz.
	input wire logic    rst,     // Synchronous reset, active high.
	ldpt_link_if.tickgen lnk     // Clock select in, tick out.
);

	// Phase and registered tick form the whole state.
	typedef struct packed {
		logic [ldpt_pkg::PHASE_W-1:0] phase; // Accumulated phase.
		logic                         tick;  // Tick pulse.
	} ldpt_tg_state_t;

	ldpt_tg_state_t st;      // Current state.
	ldpt_tg_state_t next_st; // Next state.

	// The slow count rate does not divide 40 MHz evenly, so the accumulator
	// keeps the long-term rate exact at the cost of one cycle of jitter per tick.
	always_comb begin
		logic [ldpt_pkg::PHASE_W-1:0] sum;
		sum = st.phase + (lnk.slow_sel ? ldpt_pkg::STEP_SLOW : ldpt_pkg::STEP_FAST);
		next_st = st;
		if (sum >= ldpt_pkg::PHASE_MOD) begin
			next_st.phase = sum - ldpt_pkg::PHASE_MOD;
			next_st.tick  = 1'b1;
		end else begin
			next_st.phase = sum;
			next_st.tick  = 1'b0;
		end
		if (rst) begin
			next_st.phase = ldpt_pkg::PHASE_ZERO;
			next_st.tick  = 1'b0;
		end
	end

	// State register.
	always_ff @(posedge clk_sys) begin
		st <= next_st;
	end

	assign lnk.count_tick = st.tick;

endmodule : ldpt_tick_gen

/* logic/ldpt_term_lut.sv */
// Table of terminal counts for each mode code.
`timescale 1ns/1ps
module ldpt_term_lut (
	ldpt_link_if.lut lnk // Mode in, terminal count out.
);

	// The same counts serve both clocks; the slow clock scales every rate by itself.
	always_comb begin
		unique case (lnk.mode)
			3'h0: lnk.term_value = ldpt_pkg::COUNT_ALL_ONES; // Timestamp wraps at all ones.
			3'h1: lnk.term_value = ldpt_pkg::TERM_RATE_1;    // 100 Hz or 3.2768 Hz.
			3'h2: lnk.term_value = ldpt_pkg::TERM_RATE_2;    // 200 Hz or 6.5536 Hz.
			3'h3: lnk.term_value = ldpt_pkg::TERM_RATE_3;    // 500 Hz or 16.384 Hz.
			3'h4: lnk.term_value = ldpt_pkg::TERM_RATE_4;    // 1000 Hz or 32.768 Hz.
			3'h5: lnk.term_value = ldpt_pkg::TERM_RATE_5;    // 2000 Hz or 65.536 Hz.
			3'h6: lnk.term_value = ldpt_pkg::TERM_RATE_6;    // 5000 Hz or 163.84 Hz.
			3'h7: lnk.term_value = ldpt_pkg::TERM_RATE_7;    // 10000 Hz or 327.68 Hz.
		endcase
	end

endmodule : ldpt_term_lut

/* logic/ldpt_timer.sv */
// Long duration and periodic tick timer with its I/O register file.
`timescale 1ns/1ps

module ldpt_timer (
	input  wire logic        clk_sys,      // System clock, 40 MHz.
	input  wire logic        rst,          // Board reset, synchronous, active high.
	input  wire logic        power_on_rst, // Power-on reset, synchronous, active high.
	input  wire logic [15:0] io_addr,      // I/O byte address.
	input  wire logic        io_rd,        // Read strobe, one cycle.
	input  wire logic        io_wr,        // Write strobe, one cycle.
	input  wire logic        io_dword,     // High for a 32-bit access, low for a byte.
	input  wire logic [31:0] io_wdata,     // Write data, bytes in the low lane.
	output logic      [31:0] io_rdata,     // Read data, registered.
	output logic             io_rvalid,    // Read data valid, one-cycle pulse.
	output logic             tick_irq      // Interrupt request, active high level.
);

	// Every flip-flop of the core lives in this one struct.
	typedef struct packed {
		logic [31:0] count;     // Live counter.
		logic [31:0] hold;      // Holding register seen by reads.
		logic        irq_en;    // Interrupt enable.
		logic        slow_sel;  // Count clock select.
		logic        flag;      // Wrap event flag.
		logic [2:0]  mode;      // Mode field.
		logic        run;       // Run bit.
		logic [31:0] rdata;     // Registered read data.
		logic        rvalid;    // Registered read valid.
		logic        irq;       // Registered interrupt request.
	} ldpt_core_state_t;

	ldpt_core_state_t st;      // Current state.
	ldpt_core_state_t next_st; // Next state.

	ldpt_link_if lnk ();       // Links to the tick generator and the table.

	logic at_term;             // Counter has reached the interval's last value.
	logic step;                // Counter advances in this cycle.
	logic wrap;                // Interval ends or the counter rolls over.
	logic ctrl_wr;             // Byte write to the status and control register.
	logic dword_at_base;       // The access is a 32-bit access at the lowest byte.

	// Tick source; it follows the clock select bit held in the core.
	ldpt_tick_gen u_tick_gen (
		.clk_sys (clk_sys),
		.rst     (rst),
		.lnk     (lnk)
	);

	// Terminal count for the selected mode.
	ldpt_term_lut u_term_lut (
		.lnk (lnk)
	);

	// The select and mode fields steer the helpers directly from the register.
	assign lnk.slow_sel = st.slow_sel;
	assign lnk.mode     = st.mode;

	// Status byte as software sees it; the reserved bit reads zero.
	function automatic logic [7:0] status_byte(input ldpt_core_state_t s);
		logic [7:0] b;
		b = ldpt_pkg::RESERVED_ZERO;
		b[ldpt_pkg::CTRL_IRQ_EN_BIT]  = s.irq_en;
		b[ldpt_pkg::CTRL_CLK_SEL_BIT] = s.slow_sel;
		b[ldpt_pkg::CTRL_FLAG_BIT]    = s.flag;
		b[ldpt_pkg::CTRL_MODE_LSB +: ldpt_pkg::MODE_W] = s.mode;
		b[ldpt_pkg::CTRL_RUN_BIT]     = s.run;
		return b;
	endfunction : status_byte

	// Event decode. A greater-or-equal compare is used so that a count preset above
	// the terminal value still returns to zero on the next tick instead of running
	// the whole 32-bit range first.
	always_comb begin
		at_term       = (st.count >= lnk.term_value);
		step          = st.run && lnk.count_tick;
		wrap          = step && at_term;
		ctrl_wr       = io_wr && !io_dword && (io_addr == ldpt_pkg::ADDR_STATUS_CTRL);
		dword_at_base = io_dword && (io_addr == ldpt_pkg::ADDR_COUNT_BYTE0);
	end

	// Next-state logic: counting, register writes, register reads and resets.
	always_comb begin
		next_st = st;

		// Read valid is a one-cycle pulse.
		next_st.rvalid = 1'b0;

		// Counting. In timestamp mode the terminal value is all ones, so the same
		// path gives the rollover to zero.
		if (step) begin
			if (at_term) begin
				next_st.count = ldpt_pkg::RST_COUNT;
			end else begin
				next_st.count = st.count + 32'h1;
			end
		end

		// Counter writes. A write while running is not guarded: software is expected
		// to stop the counter first, and a write here simply wins over the step.
		if (io_wr) begin
			if (dword_at_base) begin
				next_st.count = io_wdata;
			end else if (!io_dword) begin
				for (int k = 0; k < ldpt_pkg::COUNT_BYTES; k++) begin
					if (io_addr == ldpt_pkg::ADDR_COUNT_BYTE0 + 16'(k)) begin
						next_st.count[k*ldpt_pkg::BYTE_W +: ldpt_pkg::BYTE_W] =
							io_wdata[ldpt_pkg::BYTE_W-1:0];
					end
				end
			end
		end

		// Control writes. The flag is only ever cleared by software, never set.
		if (ctrl_wr) begin
			next_st.irq_en   = io_wdata[ldpt_pkg::CTRL_IRQ_EN_BIT];
			next_st.slow_sel = io_wdata[ldpt_pkg::CTRL_CLK_SEL_BIT];
			next_st.mode     = io_wdata[ldpt_pkg::CTRL_MODE_LSB +: ldpt_pkg::MODE_W];
			next_st.run      = io_wdata[ldpt_pkg::CTRL_RUN_BIT];
			if (!io_wdata[ldpt_pkg::CTRL_FLAG_BIT]) begin
				next_st.flag = 1'b0;
			end
		end

		// An event in the same cycle as a clearing write still lands, so the
		// interrupt service routine cannot lose an interval.
		if (wrap) begin
			next_st.flag = 1'b1;
		end

		// Reads. Only a read of the lowest byte, alone or within a dword, refreshes
		// the holding register, so a byte-by-byte read sees one stable count.
		if (io_rd) begin
			next_st.rvalid = 1'b1;
			next_st.rdata  = ldpt_pkg::READ_IDLE;
			if (io_dword) begin
				if (dword_at_base) begin
					next_st.hold  = st.count;
					next_st.rdata = st.count;
				end
			end else begin
				unique case (io_addr)
					ldpt_pkg::ADDR_COUNT_BYTE0: begin
						next_st.hold  = st.count;
						next_st.rdata = {24'h0, st.count[7:0]};
					end
					ldpt_pkg::ADDR_COUNT_BYTE1: begin
						next_st.rdata = {24'h0, st.hold[15:8]};
					end
					ldpt_pkg::ADDR_COUNT_BYTE2: begin
						next_st.rdata = {24'h0, st.hold[23:16]};
					end
					ldpt_pkg::ADDR_COUNT_BYTE3: begin
						next_st.rdata = {24'h0, st.hold[31:24]};
					end
					ldpt_pkg::ADDR_STATUS_CTRL: begin
						next_st.rdata = {24'h0, status_byte(st)};
					end
					default: begin
						next_st.rdata = ldpt_pkg::READ_IDLE;
					end
				endcase
			end
		end

		// Board reset returns the control byte to its defaults but leaves the
		// counter and the holding register alone, so a timestamp survives it.
		if (rst) begin
			next_st.irq_en   = ldpt_pkg::RST_IRQ_EN;
			next_st.slow_sel = ldpt_pkg::RST_CLK_SEL;
			next_st.flag     = ldpt_pkg::RST_FLAG;
			next_st.mode     = ldpt_pkg::RST_MODE;
			next_st.run      = ldpt_pkg::RST_RUN;
			next_st.rdata    = ldpt_pkg::READ_IDLE;
			next_st.rvalid   = 1'b0;
		end

		// Power-on reset clears every core register, the counter included, but not the tick generator.
		if (power_on_rst) begin
			next_st.count    = ldpt_pkg::RST_COUNT;
			next_st.hold     = ldpt_pkg::RST_COUNT;
			next_st.irq_en   = ldpt_pkg::RST_IRQ_EN;
			next_st.slow_sel = ldpt_pkg::RST_CLK_SEL;
			next_st.flag     = ldpt_pkg::RST_FLAG;
			next_st.mode     = ldpt_pkg::RST_MODE;
			next_st.run      = ldpt_pkg::RST_RUN;
			next_st.rdata    = ldpt_pkg::READ_IDLE;
			next_st.rvalid   = 1'b0;
		end

		// The request is computed from the next flag and enable so that the pin
		// changes on the same edge as the bits software can read.
		next_st.irq = next_st.flag && next_st.irq_en;
	end

	// State register; both resets are folded into the next-state logic above.
	always_ff @(posedge clk_sys) begin
		st <= next_st;
	end

	// Outputs come straight from the state register.
	assign io_rdata  = st.rdata;
	assign io_rvalid = st.rvalid;
	assign tick_irq  = st.irq;

endmodule : ldpt_timer

/* verif/ldpt_host.sv */
// Host software model that issues byte and dword I/O cycles to the timer.
`timescale 1ns/1ps
module ldpt_host (
	input  wire logic        clk_sys,   // System clock.
	input  wire logic [31:0] io_rdata,  // Read data from the timer.
	input  wire logic        io_rvalid, // Read data valid.
	output logic      [15:0] io_addr,   // I/O byte address.
	output logic             io_rd,     // Read strobe.
	output logic             io_wr,     // Write strobe.
	output logic             io_dword,  // Dword access.
	output logic      [31:0] io_wdata   // Write data.
);
	// The bus idles with no strobe from time zero.
	initial begin
		io_addr  = 16'h0000;
		io_rd    = 1'b0;
		io_wr    = 1'b0;
		io_dword = 1'b0;
		io_wdata = 32'h0;
	end
	// One write pulse; address and data flip afterwards so a stale value never looks valid.
	task automatic wr(input logic [15:0] a, input logic dw, input logic [31:0] v);
		@(posedge clk_sys);
		io_addr  <= a;
		io_dword <= dw;
		io_wdata <= v;
		io_wr    <= 1'b1;
		@(posedge clk_sys);
		io_wr    <= 1'b0;
		io_addr  <= ~a;
		io_wdata <= ~v;
	endtask : wr
	// One read pulse; data is taken mid-cycle once the answer has settled.
	task automatic rd(input logic [15:0] a, input logic dw, output logic [31:0] v);
		@(posedge clk_sys);
		io_addr  <= a;
		io_dword <= dw;
		io_rd    <= 1'b1;
		@(posedge clk_sys);
		io_rd    <= 1'b0;
		io_addr  <= ~a;
		@(negedge clk_sys);
		v = (io_rvalid === 1'b1) ? io_rdata : 32'hxxxxxxxx;
	endtask : rd
endmodule : ldpt_host

/* verif/ldpt_timer_chk.sv */
// Concurrent checks on the timer's register bus and interrupt pin.
`timescale 1ns/1ps
module ldpt_timer_chk (
	input wire logic        clk_sys,      // System clock.
	input wire logic        rst,          // Board reset.
	input wire logic        power_on_rst, // Power-on reset.
	input wire logic [15:0] io_addr,      // Address.
	input wire logic        io_rd,        // Read strobe.
	input wire logic        io_wr,        // Write strobe.
	input wire logic        io_dword,     // Dword access.
	input wire logic [31:0] io_wdata,     // Write data.
	input wire logic [31:0] io_rdata,     // Read data.
	input wire logic        io_rvalid,    // Read valid.
	input wire logic        tick_irq      // Interrupt request.
);
	default clocking @(posedge clk_sys);
	endclocking
	default disable iff (rst || power_on_rst);
	// A byte access of one address.
	sequence s_byte(logic en, logic [15:0] a);
		en && !io_dword && io_addr == a;
	endsequence
	// Control write, one idle cycle, control read.
	sequence s_ctrl_wr_rd;
		s_byte(io_wr, ldpt_pkg::ADDR_STATUS_CTRL) ##1 !io_wr ##1 s_byte(io_rd, ldpt_pkg::ADDR_STATUS_CTRL);
	endsequence
	// Dword capture, one idle cycle, top byte read.
	sequence s_dw_top;
		io_rd && io_dword && io_addr == ldpt_pkg::ADDR_COUNT_BYTE0 ##1 !io_rd ##1
			s_byte(io_rd, ldpt_pkg::ADDR_COUNT_BYTE3);
	endsequence
	property p_rd_answer;
		io_rd |=> io_rvalid;
	endproperty
	property p_no_stray;
		io_rvalid |-> $past(io_rd);
	endproperty
	property p_byte_lane;
		io_rvalid && !$past(io_dword) |-> io_rdata[31:8] == 24'h0;
	endproperty
	property p_unmapped;
		io_rd && !io_dword && (io_addr < ldpt_pkg::ADDR_COUNT_BYTE0 || io_addr > ldpt_pkg::ADDR_STATUS_CTRL)
			|=> io_rdata == 32'h0;
	endproperty
	property p_irq_masked;
		s_byte(io_wr, ldpt_pkg::ADDR_STATUS_CTRL) and !io_wdata[7] |=> !tick_irq;
	endproperty
	property p_ctrl_readback;
		s_ctrl_wr_rd |=> (io_rdata[7:0] & 8'hef) == ($past(io_wdata[7:0], 3) & 8'haf);
	endproperty
	property p_hold_top;
		s_dw_top |=> io_rdata[7:0] == $past(io_rdata[31:24], 2);
	endproperty
	property p_reset_quiet;
		$fell(rst) |-> !tick_irq && !io_rvalid && io_rdata == 32'h0;
	endproperty
	a_rd_answer: assert property (p_rd_answer)
		else $error("read not answered in one cycle");
	a_no_stray: assert property (p_no_stray)
		else $error("read valid without a read");
	a_byte_lane: assert property (p_byte_lane)
		else $error("byte read with upper lanes set");
	a_unmapped: assert property (p_unmapped)
		else $error("unmapped read not zero");
	a_irq_masked: assert property (p_irq_masked)
		else $error("interrupt high while disabled");
	a_ctrl_readback: assert property (p_ctrl_readback)
		else $error("control byte read back wrong");
	a_hold_top: assert property (p_hold_top)
		else $error("top byte differs from held count");
	a_reset_quiet: assert property (p_reset_quiet)
		else $error("outputs active after reset");
endmodule : ldpt_timer_chk

bind ldpt_timer ldpt_timer_chk i_chk (.clk_sys(clk_sys), .rst(rst), .power_on_rst(power_on_rst),
	.io_addr(io_addr), .io_rd(io_rd), .io_wr(io_wr), .io_dword(io_dword), .io_wdata(io_wdata),
	.io_rdata(io_rdata), .io_rvalid(io_rvalid), .tick_irq(tick_irq));

/* verif/ldpt_timer_tb.sv */
// Self-checking testbench of the long duration periodic timer.
`timescale 1ns/1ps
module ldpt_timer_tb;
	localparam logic [15:0] A0 = ldpt_pkg::ADDR_COUNT_BYTE0; // Lowest counter byte.
	localparam logic [15:0] CT = ldpt_pkg::ADDR_STATUS_CTRL; // Control byte.
	logic        clk_sys      = 1'b0; // System clock, 40 MHz.
	logic        rst          = 1'b1; // Board reset.
	logic        power_on_rst = 1'b1; // Power-on reset.
	logic [15:0] io_addr;             // Bus address.
	logic        io_rd;               // Read strobe.
	logic        io_wr;               // Write strobe.
	logic        io_dword;            // Dword access.
	logic [31:0] io_wdata;            // Write data.
	logic [31:0] io_rdata;            // Read data.
	logic        io_rvalid;           // Read valid.
	logic        tick_irq;            // Interrupt request.
	logic [31:0] d;                   // Last value read.
	int          n_mismatch = 0;      // Mismatches seen.
	int          n_compared = 0;      // Comparisons made.
	int          rate [8] = '{0, 100, 200, 500, 1000, 2000, 5000, 10000}; // Rates at 1 MHz.
	// Half period of 12.5 ns gives 40 MHz.
	always #12.5 clk_sys = ~clk_sys;
	ldpt_timer i_dut (.clk_sys(clk_sys), .rst(rst), .power_on_rst(power_on_rst), .io_addr(io_addr),
		.io_rd(io_rd), .io_wr(io_wr), .io_dword(io_dword), .io_wdata(io_wdata), .io_rdata(io_rdata),
		.io_rvalid(io_rvalid), .tick_irq(tick_irq));
	ldpt_host i_host (.clk_sys(clk_sys), .io_rdata(io_rdata), .io_rvalid(io_rvalid), .io_addr(io_addr),
		.io_rd(io_rd), .io_wr(io_wr), .io_dword(io_dword), .io_wdata(io_wdata));
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic chk_rng(input string what, input logic [31:0] lo, input logic [31:0] hi, input logic [31:0] got);
		n_compared++;
		if (((got >= lo) && (got <= hi)) !== 1'b1) begin
			n_mismatch++;
			$display("wrong value %s expected %0d to %0d seen %0d", what, lo, hi, got);
		end
	endtask : chk_rng
	task automatic wb(input logic [15:0] a, input logic [7:0] v);
		i_host.wr(a, 1'b0, {24'h0, v});
	endtask : wb
	// Waits mid-cycle for the interrupt, giving up at a bound.
	task automatic wait_irq(input int lim, output int n);
		n = 0;
		while (tick_irq !== 1'b1 && n < lim) begin
			@(negedge clk_sys);
			n++;
		end
	endtask : wait_irq
	task automatic t_reset;
		i_host.rd(CT, 1'b0, d);
		chk("control after reset", 32'h0, d);
		i_host.rd(A0, 1'b1, d);
		chk("count after power-on", 32'h0, d);
		$display("test reset done");
	endtask : t_reset
	// Byte writes reach the live count only; upper reads come from the held copy.
	task automatic t_bytes;
		wb(CT, 8'h00);
		for (int i = 0; i < 4; i++) wb(A0 + 16'(i), 8'(8'h11 * (i + 1)));
		i_host.rd(A0, 1'b1, d);
		chk("dword count", 32'h44332211, d);
		i_host.rd(A0 + 16'h3, 1'b0, d);
		chk("top byte", 32'h44, d);
		for (int i = 1; i < 4; i++) wb(A0 + 16'(i), 8'(8'h44 + 8'h11 * i));
		i_host.rd(A0 + 16'h1, 1'b0, d);
		chk("byte1 held", 32'h22, d);
		i_host.rd(A0 + 16'h2, 1'b0, d);
		chk("byte2 held", 32'h33, d);
		i_host.rd(A0, 1'b0, d);
		chk("byte0 capture", 32'h11, d);
		i_host.rd(A0 + 16'h3, 1'b0, d);
		chk("top after capture", 32'h77, d);
		i_host.rd(16'h021d, 1'b0, d);
		chk("unmapped read", 32'h0, d);
		$display("test bytes done");
	endtask : t_bytes
	task automatic t_stopped;
		i_host.wr(A0, 1'b1, 32'hffffffff);
		wb(CT, 8'h80);
		repeat (200) @(negedge clk_sys);
		chk("irq while stopped", 32'h0, {31'h0, tick_irq});
		i_host.rd(A0, 1'b1, d);
		chk("stopped count", 32'hffffffff, d);
		$display("test stopped done");
	endtask : t_stopped
	// Sixteen 1 us ticks from the preset reach the wrap.
	task automatic t_stamp;
		int n;
		i_host.wr(A0, 1'b1, 32'hfffffff0);
		wb(CT, 8'h81);
		wait_irq(900, n);
		chk_rng("wrap cycles", 32'd590, 32'd650, 32'(n));
		i_host.rd(A0, 1'b1, d);
		chk_rng("count after wrap", 32'd0, 32'd1, d);
		wb(CT, 8'h90);
		i_host.rd(CT, 1'b0, d);
		chk("flag kept", 32'h90, d);
		wb(CT, 8'h10);
		@(negedge clk_sys);
		chk("irq disabled", 32'h0, {31'h0, tick_irq});
		wb(CT, 8'h00);
		i_host.rd(CT, 1'b0, d);
		chk("flag cleared", 32'h0, d);
		$display("test timestamp done");
	endtask : t_stamp
	// Each mode starts three counts short of its terminal, so four ticks end the interval.
	task automatic t_periodic;
		int n;
		for (int m = 1; m < 8; m++) begin
			wb(CT, 8'h00);
			i_host.wr(A0, 1'b1, 32'(1000000 / rate[m] - 4));
			wb(CT, 8'(8'h81 | (m << 1)));
			wait_irq(400, n);
			chk_rng("interval cycles", 32'd110, 32'd190, 32'(n));
			i_host.rd(A0, 1'b1, d);
			chk_rng("count after interval", 32'd0, 32'd1, d);
		end
		$display("test periodic done");
	endtask : t_periodic
	// Two slow ticks take some 2441 cycles; the fast clock would need only 80.
	task automatic t_slow;
		int n;
		wb(CT, 8'h00);
		i_host.wr(A0, 1'b1, 32'd98);
		wb(CT, 8'haf);
		wait_irq(3000, n);
		chk_rng("slow cycles", 32'd1200, 32'd2460, 32'(n));
		i_host.rd(CT, 1'b0, d);
		chk("slow control", 32'hbf, d);
		wb(CT, 8'h00);
		$display("test slow done");
	endtask : t_slow
	// Board reset keeps the count; only power-on clears it.
	task automatic t_keep;
		i_host.wr(A0, 1'b1, 32'h12345678);
		wb(CT, 8'h80);
		@(posedge clk_sys);
		rst <= 1'b1;
		repeat (2) @(posedge clk_sys);
		rst <= 1'b0;
		i_host.rd(A0, 1'b1, d);
		chk("count over reset", 32'h12345678, d);
		i_host.rd(CT, 1'b0, d);
		chk("control after reset", 32'h0, d);
		@(posedge clk_sys);
		power_on_rst <= 1'b1;
		repeat (2) @(posedge clk_sys);
		power_on_rst <= 1'b0;
		i_host.rd(A0, 1'b1, d);
		chk("count after power-on", 32'h0, d);
		$display("test keep done");
	endtask : t_keep
	task automatic end_sim;
		$display("compared %0d mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : end_sim
	// Reset for eight cycles, then the tests in turn.
	initial begin
		repeat (8) @(posedge clk_sys);
		rst          <= 1'b0;
		power_on_rst <= 1'b0;
		t_reset;
		t_bytes;
		t_stopped;
		t_stamp;
		t_periodic;
		t_slow;
		t_keep;
		end_sim;
	end
	// The tests need about 4500 cycles; far beyond that means a hang.
	initial begin
		repeat (30000) @(posedge clk_sys);
		n_mismatch++;
		$display("watchdog expired");
		end_sim;
	end
endmodule : ldpt_timer_tb
